// File: logic/mstat_pkg.sv
// constants and types for the i2c master status logic
// ----------------------------------------------------------------------------
// Function
// - bit 14 shows filtered clock line level, reset value one
// - bit 13 shows filtered data line level, reset value one
// - bit 12 tx underflow set on empty-fifo termination when tx irq enabled; read clears
// - bit 11 set only when this master drives stop; no interrupt; read clears
// - bit 10 bus busy set on start, cleared on stop
// - bit 9 set when byte written into full rx fifo; read clears
// - bit 8 set on any stop while master enabled; interrupt if enabled; read clears
// - bit 7 set on data byte not acknowledged; interrupt if enabled; read clears
// - bit 6 high while master enabled and its state machine services a transaction
// - bit 5 set on arbitration loss; interrupt if enabled; read clears
// - bit 4 set on address not acknowledged; interrupt if enabled; read clears
// - bit 3 high while rx fifo holds data; interrupt if enabled
// - bit 2 high when direction write and tx fifo not full; interrupt if enabled
// - bits 1:0 tx fifo level: 00 empty, 10 one byte, 11 full
// - status register 16 bits, resets to 0x6000 apart from bits 3, 2 and 1:0, which follow the engine levels
// - clearing master enable gates the master clock; keep enabled until done
// ----------------------------------------------------------------------------
package mstat_pkg;
    localparam logic [31:0] ctrl_addr = 32'h40003000;
    localparam logic [31:0] status_addr = 32'h40003004;
    localparam logic [31:0] irq_status_addr = 32'h40003100;
    localparam logic [31:0] irq_enable_addr = 32'h40003104;
    localparam logic [31:0] irq_clear_addr = 32'h40003108;
    localparam int addr_w = 32;
    localparam logic [15:0] status_reset = 16'h6000;
    localparam int bit_scl = 14;
    localparam int bit_sda = 13;
    localparam int bit_txuf = 12;
    localparam int bit_ostop = 11;
    localparam int bit_busy = 10;
    localparam int bit_rxof = 9;
    localparam int bit_done = 8;
    localparam int bit_dnak = 7;
    localparam int bit_mact = 6;
    localparam int bit_arbitration_lost_flag = 5;
    localparam int bit_anak = 4;
    localparam int bit_rxreq = 3;
    localparam int bit_txreq = 2;
    localparam int ctl_done_ie = 8;
    localparam int ctl_nak_ie = 7;
    localparam int ctl_arbitration_lost_flag_ie = 6;
    localparam int ctl_tx_ie = 5;
    localparam int ctl_rx_ie = 4;
    localparam int ctl_on = 0;
    localparam logic [15:0] ctrl_mask = 16'h01f1;
    localparam logic [1:0] lvl_empty = 2'h0;
    localparam logic [1:0] lvl_one = 2'h2;
    localparam logic [1:0] lvl_full = 2'h3;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    localparam logic [2:0] filt_len = 3'h3;

    // events from the protocol engine, one-cycle pulses
    typedef struct packed {
        logic start_seen;
        logic stop_seen;
        logic own_stop;
        logic tx_empty_end;
        logic rx_write_full;
        logic data_noack;
        logic addr_noack;
        logic arb_lost;
    } engine_event_type;

    // levels from the engine and fifos
    typedef struct packed {
        logic servicing;
        logic dir_read;
        logic rx_has_data;
        logic [1:0] tx_count;
    } engine_level_type;
endpackage

// File: logic/i2c_master_status.sv
// i2c master status register with axi4-lite slave and interrupt
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/100ps
module i2c_master_status
    import mstat_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [addr_w-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [addr_w-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire engine_event_type ev,
    input wire engine_level_type lv,
    output logic master_clk_en,
    output logic irq
);

// ----------------------------------------------------------------------------
// glitch filters
// ----------------------------------------------------------------------------
logic [2:0] scl_cnt_ff;
logic [2:0] sda_cnt_ff;
logic scl_raw_ff;
logic sda_raw_ff;
logic scl_f_ff;
logic sda_f_ff;

function automatic logic [2:0] filt_next(input logic raw, input logic cur, input logic [2:0] c);
    if (raw == cur) begin
        filt_next = 3'h0;
    end else begin
        filt_next = c + 3'h1;
    end
endfunction

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        scl_raw_ff <= 1'b1;
        sda_raw_ff <= 1'b1;
        scl_cnt_ff <= 3'h0;
        sda_cnt_ff <= 3'h0;
        scl_f_ff <= 1'b1;
        sda_f_ff <= 1'b1;
    end else begin
        scl_raw_ff <= scl_in;
        sda_raw_ff <= sda_in;
        scl_cnt_ff <= filt_next(scl_raw_ff, scl_f_ff, scl_cnt_ff);
        sda_cnt_ff <= filt_next(sda_raw_ff, sda_f_ff, sda_cnt_ff);
        if (filt_next(scl_raw_ff, scl_f_ff, scl_cnt_ff) == filt_len) begin
            scl_f_ff <= scl_raw_ff;
            scl_cnt_ff <= 3'h0;
        end
        if (filt_next(sda_raw_ff, sda_f_ff, sda_cnt_ff) == filt_len) begin
            sda_f_ff <= sda_raw_ff;
            sda_cnt_ff <= 3'h0;
        end
    end
end

// ----------------------------------------------------------------------------
// bus write channel
// ----------------------------------------------------------------------------
logic aw_got_ff;
logic w_got_ff;
logic [addr_w-1:0] aw_addr_ff;
logic [31:0] w_data_ff;
logic [3:0] w_strb_ff;
logic bvalid_ff;
logic [1:0] bresp_ff;
logic do_write;
logic awready_ff;
logic wready_ff;
logic nxt_aw_got;
logic nxt_w_got;
logic nxt_bvalid;

assign s_axi_awready = awready_ff;
assign s_axi_wready = wready_ff;
assign s_axi_bvalid = bvalid_ff;
assign s_axi_bresp = bresp_ff;
assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;

// next channel state, so the ready flags can be registered
always_comb begin
    nxt_aw_got = aw_got_ff || (s_axi_awvalid && awready_ff);
    nxt_w_got = w_got_ff || (s_axi_wvalid && wready_ff);
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    if (do_write) begin
        nxt_aw_got = 1'b0;
        nxt_w_got = 1'b0;
        nxt_bvalid = 1'b1;
    end
end

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
    end else begin
        awready_ff <= !nxt_aw_got && !nxt_bvalid;
        wready_ff <= !nxt_w_got && !nxt_bvalid;
    end
end

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        aw_addr_ff <= '0;
        w_data_ff <= 32'h0;
        w_strb_ff <= 4'h0;
        bvalid_ff <= 1'b0;
        bresp_ff <= resp_okay;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_ff <= 1'b1;
            aw_addr_ff <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_ff <= 1'b1;
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
        end
        if (do_write) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            bvalid_ff <= 1'b1;
            case (aw_addr_ff)
                ctrl_addr, irq_enable_addr, irq_clear_addr: begin
                    bresp_ff <= resp_okay;
                end
                status_addr, irq_status_addr: begin
                    bresp_ff <= resp_okay;
                end
                default: begin
                    bresp_ff <= resp_slverr;
                end
            endcase
        end else if (bvalid_ff && s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end
end

function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge16 = old;
    if (s[0]) begin
        merge16[7:0] = d[7:0];
    end
    if (s[1]) begin
        merge16[15:8] = d[15:8];
    end
endfunction

// ----------------------------------------------------------------------------
// control and interrupt registers
// ----------------------------------------------------------------------------
logic [15:0] ctrl_ff;
logic [15:0] ien_ff;
logic [15:0] iclr;

assign iclr = (do_write && aw_addr_ff == irq_clear_addr) ? merge16(16'h0, w_data_ff, w_strb_ff)
                                                        : 16'h0;

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        ctrl_ff <= 16'h0;
        ien_ff <= 16'h0;
    end else if (do_write) begin
        if (aw_addr_ff == ctrl_addr) begin
            ctrl_ff <= merge16(ctrl_ff, w_data_ff, w_strb_ff) & ctrl_mask;
        end
        if (aw_addr_ff == irq_enable_addr) begin
            ien_ff <= merge16(ien_ff, w_data_ff, w_strb_ff);
        end
    end
end

logic master_on;
assign master_on = ctrl_ff[ctl_on];

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        master_clk_en <= 1'b0;
    end else begin
        master_clk_en <= master_on;
    end
end

// ----------------------------------------------------------------------------
// read channel
// ----------------------------------------------------------------------------
logic rvalid_ff;
logic [31:0] rdata_ff;
logic [1:0] rresp_ff;
logic status_read;
logic [15:0] status_word;
logic [15:0] ist_ff;
logic arready_ff;
logic nxt_rvalid;

assign s_axi_arready = arready_ff;
assign nxt_rvalid = (s_axi_arvalid && arready_ff) || (rvalid_ff && !s_axi_rready);
assign s_axi_rvalid = rvalid_ff;
assign s_axi_rdata = rdata_ff;
assign s_axi_rresp = rresp_ff;
assign status_read = s_axi_arvalid && s_axi_arready && s_axi_araddr == status_addr;

// one read in flight: address refused while an answer stands
always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        arready_ff <= 1'b1;
    end else begin
        arready_ff <= !nxt_rvalid;
    end
end

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        rvalid_ff <= 1'b0;
        rdata_ff <= 32'h0;
        rresp_ff <= resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= resp_okay;
        case (s_axi_araddr)
            ctrl_addr: rdata_ff <= {16'h0, ctrl_ff};
            status_addr: rdata_ff <= {16'h0, status_word};
            irq_status_addr: rdata_ff <= {16'h0, ist_ff};
            irq_enable_addr: rdata_ff <= {16'h0, ien_ff};
            irq_clear_addr: rdata_ff <= 32'h0;
            default: begin
                rdata_ff <= 32'h0;
                rresp_ff <= resp_slverr;
            end
        endcase
    end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
    end
end

// ----------------------------------------------------------------------------
// status flags
// ----------------------------------------------------------------------------
logic txuf_ff;
logic ostop_ff;
logic busy_ff;
logic rxof_ff;
logic done_ff;
logic dnak_ff;
logic arbitration_lost_flag_ff;
logic anak_ff;
logic tx_req;
logic [1:0] tx_level;

// set wins over a read in the same cycle
function automatic logic sticky(input logic cur, input logic set, input logic clr);
    sticky = set | (cur & !clr);
endfunction

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        txuf_ff <= 1'b0;
        ostop_ff <= 1'b0;
        rxof_ff <= 1'b0;
        done_ff <= 1'b0;
        dnak_ff <= 1'b0;
        arbitration_lost_flag_ff <= 1'b0;
        anak_ff <= 1'b0;
    end else begin
        txuf_ff <= sticky(txuf_ff, ev.tx_empty_end && ctrl_ff[ctl_tx_ie], status_read);
        ostop_ff <= sticky(ostop_ff, ev.own_stop, status_read);
        rxof_ff <= sticky(rxof_ff, ev.rx_write_full, status_read);
        done_ff <= sticky(done_ff, ev.stop_seen && master_on, status_read);
        dnak_ff <= sticky(dnak_ff, ev.data_noack, status_read);
        arbitration_lost_flag_ff <= sticky(arbitration_lost_flag_ff, ev.arb_lost, status_read);
        anak_ff <= sticky(anak_ff, ev.addr_noack, status_read);
    end
end

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        busy_ff <= 1'b0;
    end else if (ev.start_seen) begin
        busy_ff <= 1'b1;
    end else if (ev.stop_seen) begin
        busy_ff <= 1'b0;
    end
end

assign tx_req = !lv.dir_read && lv.tx_count != 2'h2;
assign tx_level = (lv.tx_count == 2'h0) ? lvl_empty :
                  (lv.tx_count == 2'h1) ? lvl_one : lvl_full;

always_comb begin
    status_word = 16'h0;
    status_word[bit_scl] = scl_f_ff;
    status_word[bit_sda] = sda_f_ff;
    status_word[bit_txuf] = txuf_ff;
    status_word[bit_ostop] = ostop_ff;
    status_word[bit_busy] = busy_ff;
    status_word[bit_rxof] = rxof_ff;
    status_word[bit_done] = done_ff;
    status_word[bit_dnak] = dnak_ff;
    status_word[bit_mact] = lv.servicing && master_on;
    status_word[bit_arbitration_lost_flag] = arbitration_lost_flag_ff;
    status_word[bit_anak] = anak_ff;
    status_word[bit_rxreq] = lv.rx_has_data;
    status_word[bit_txreq] = tx_req;
    status_word[1:0] = tx_level;
end

// ----------------------------------------------------------------------------
// interrupt status, enable, clear
// ----------------------------------------------------------------------------
logic [15:0] irq_src;
logic [15:0] ist_set;

always_comb begin
    irq_src = 16'h0;
    irq_src[bit_done] = done_ff && ctrl_ff[ctl_done_ie];
    irq_src[bit_dnak] = dnak_ff && ctrl_ff[ctl_nak_ie];
    irq_src[bit_anak] = anak_ff && ctrl_ff[ctl_nak_ie];
    irq_src[bit_arbitration_lost_flag] = arbitration_lost_flag_ff && ctrl_ff[ctl_arbitration_lost_flag_ie];
    irq_src[bit_rxreq] = lv.rx_has_data && ctrl_ff[ctl_rx_ie];
    irq_src[bit_txreq] = tx_req && ctrl_ff[ctl_tx_ie];
end

assign ist_set = irq_src;

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        ist_ff <= 16'h0;
    end else begin
        ist_ff <= ist_set | (ist_ff & ~iclr);
    end
end

always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        irq <= 1'b0;
    end else begin
        irq <= |((ist_set | (ist_ff & ~iclr)) & ien_ff);
    end
end

endmodule // i2c_master_status

// File: dv/i2c_master_status_asserts.sv
// checker for the status read path
`timescale 1ns/100ps
module i2c_master_status_asserts
    import mstat_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [addr_w-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire engine_level_type lv
);
    logic rd_stat_ff;
    logic [1:0] lines_ff;
    logic [3:0] quiet_ff;
    engine_level_type lv_ff;
    // ---
    // helpers
    // ---
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_stat_ff <= 1'b0;
            lines_ff <= 2'h3;
            quiet_ff <= 4'h0;
            lv_ff <= '0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                rd_stat_ff <= s_axi_araddr == status_addr;
            end
            lines_ff <= {scl_in, sda_in};
            lv_ff <= lv;
            if ({scl_in, sda_in} != lines_ff) begin
                quiet_ff <= 4'h0;
            end else if (quiet_ff != 4'hf) begin
                quiet_ff <= quiet_ff + 4'h1;
            end
        end
    end
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence stat_rd;
        $rose(s_axi_rvalid) && rd_stat_ff;
    endsequence
    sequence quiet_rd;
        stat_rd ##0 (quiet_ff > 4'h9);
    endsequence
    // ---
    // properties
    // ---
    chk_scl_level: assert property (quiet_rd |-> s_axi_rdata[bit_scl] == scl_in)
        else $error("clock line bit wrong");
    chk_sda_level: assert property (quiet_rd |-> s_axi_rdata[bit_sda] == sda_in)
        else $error("data line bit wrong");
    chk_level_code: assert property (stat_rd |-> s_axi_rdata[1:0] ==
        (lv_ff.tx_count == 2'h2 ? lvl_full : lv_ff.tx_count == 2'h1 ? lvl_one : lvl_empty))
        else $error("tx level code wrong");
    chk_tx_request: assert property (stat_rd |->
        s_axi_rdata[bit_txreq] == (!lv_ff.dir_read && lv_ff.tx_count != 2'h2))
        else $error("tx request wrong");
    chk_rx_request: assert property (stat_rd |-> s_axi_rdata[bit_rxreq] == lv_ff.rx_has_data)
        else $error("rx request wrong");
    chk_active_cause: assert property (stat_rd ##0 s_axi_rdata[bit_mact] |-> lv_ff.servicing)
        else $error("busy without service");
    chk_upper_zero: assert property (stat_rd |-> s_axi_rdata[31:15] == 17'h0)
        else $error("upper bits set");
    chk_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
endmodule // i2c_master_status_asserts
bind i2c_master_status i2c_master_status_asserts u_chk (.clk, .rst_n, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
    .scl_in, .sda_in, .lv);

// File: dv/i2c_bus_model.sv
// far-side bus model: line levels and engine events
`timescale 1ns/100ps
module i2c_bus_model
    import mstat_pkg::*;
(
    input wire logic clk,
    output logic scl_in,
    output logic sda_in,
    output engine_event_type ev
);
    initial begin
        scl_in = 1'b1;
        sda_in = 1'b1;
        ev = '0;
    end
    // one-cycle event pulse
    task automatic pulse(input engine_event_type e);
        ev <= e;
        @(posedge clk);
        #1;
        ev <= '0;
        @(posedge clk);
        #1;
    endtask
    // start or stop: data moves under a high clock
    task automatic cond(input logic is_stop);
        scl_in <= scl_in | is_stop;
        sda_in <= sda_in & is_stop;
        repeat (10) @(posedge clk);
        #1;
        scl_in <= is_stop;
        sda_in <= is_stop;
        repeat (10) @(posedge clk);
        #1;
        pulse(engine_event_type'(is_stop ? 8'h40 : 8'h80));
    endtask
endmodule // i2c_bus_model

// File: dv/tb.sv
// self-checking bench for the i2c master status logic
`timescale 1ns/100ps
module tb;
    import mstat_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd_q;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr_q, br_q;
    logic scl_in, sda_in, master_clk_en, irq, aw_hs, w_hs, b_hs, ar_hs, r_hs;
    engine_event_type ev;
    engine_level_type lv = '0;
    int fails = 0;
    int total_checks = 0;
    i2c_master_status i_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .scl_in, .sda_in, .ev, .lv,
        .master_clk_en, .irq);
    i2c_bus_model i_bus (.clk, .scl_in, .sda_in, .ev);
    always #50 clk = ~clk;
    always @(posedge clk) begin
        aw_hs <= s_axi_awvalid && s_axi_awready;
        w_hs <= s_axi_wvalid && s_axi_wready;
        b_hs <= s_axi_bvalid && s_axi_bready;
        ar_hs <= s_axi_arvalid && s_axi_arready;
        r_hs <= s_axi_rvalid && s_axi_rready;
        if (s_axi_bvalid && s_axi_bready) begin
            br_q <= s_axi_bresp;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            rd_q <= s_axi_rdata;
            rr_q <= s_axi_rresp;
        end
    end
    // ---
    // bus tasks
    // ---
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            step();
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
        end while (!b_hs);
        s_axi_bready <= 1'b0;
        step();
    endtask
    task automatic rd(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            step();
            if (ar_hs) s_axi_arvalid <= 1'b0;
        end while (!r_hs);
        s_axi_rready <= 1'b0;
        step();
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    // ---
    // scenarios
    // ---
    task automatic t_reset();
        rd(status_addr);
        chk(rd_q, {16'h0, status_reset} | 32'h4, "reset value");
        rd(32'h40003200);
        chk({30'h0, rr_q}, {30'h0, resp_slverr}, "unmapped response");
        wr(32'h40003200, 32'h0);
        chk({30'h0, br_q}, {30'h0, resp_slverr}, "unmapped write");
        $display("t_reset done");
    endtask
    task automatic t_levels();
        logic [1:0] code [3] = '{lvl_empty, lvl_one, lvl_full};
        for (int i = 0; i < 6; i++) begin
            lv <= '{1'b0, i[0], i[0], i[2:1]};
            step();
            rd(status_addr);
            chk(rd_q & 32'hf, {28'h0, i[0], !i[0] && i[2:1] != 2'h2, code[i/2]}, "levels");
        end
        lv <= '0;
        $display("t_levels done");
    endtask
    task automatic t_flags();
        int map [7] = '{bit_arbitration_lost_flag, bit_anak, bit_dnak, bit_rxof, bit_txuf, bit_ostop, bit_done};
        wr(ctrl_addr, 32'h01f1);
        chk({30'h0, br_q}, {30'h0, resp_okay}, "control write");
        for (int k = 0; k < 7; k++) begin
            i_bus.pulse(engine_event_type'(8'h1 << k));
            rd(status_addr);
            chk(rd_q & 32'h1bb0, 32'h1 << map[k], "flag set");
            rd(status_addr);
            chk(rd_q & 32'h1bb0, 32'h0, "flag read clear");
        end
        $display("t_flags done");
    endtask
    task automatic t_gates();
        wr(ctrl_addr, 32'h1);
        i_bus.pulse(engine_event_type'(8'h10));
        lv.servicing <= 1'b1;
        rd(status_addr);
        chk(rd_q & 32'h1040, 32'h40, "gated underflow, busy");
        chk({31'h0, master_clk_en}, 32'h1, "clock on");
        wr(ctrl_addr, 32'h0);
        i_bus.pulse(engine_event_type'(8'h40));
        rd(status_addr);
        chk(rd_q & 32'h140, 32'h0, "master off");
        chk({31'h0, master_clk_en}, 32'h0, "clock gated");
        lv <= '0;
        $display("t_gates done");
    endtask
    task automatic t_lines();
        wr(ctrl_addr, 32'h1);
        i_bus.cond(1'b0);
        rd(status_addr);
        chk(rd_q & 32'h6400, 32'h0400, "after start");
        i_bus.cond(1'b1);
        rd(status_addr);
        chk(rd_q & 32'h6500, 32'h6100, "after stop");
        wr(ctrl_addr, 32'h0);
        $display("t_lines done");
    endtask
    task automatic t_irq();
        wr(ctrl_addr, 32'h41);
        wr(irq_enable_addr, 32'hffff);
        i_bus.pulse(engine_event_type'(8'h1));
        rd(irq_status_addr);
        chk(rd_q & 32'h20, 32'h20, "irq status");
        chk({31'h0, irq}, 32'h1, "irq raised");
        rd(status_addr);
        wr(irq_clear_addr, 32'hffff);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        wr(irq_enable_addr, 32'h0);
        i_bus.pulse(engine_event_type'(8'h1));
        rd(status_addr);
        chk(rd_q & 32'h20, 32'h20, "masked flag");
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(irq_clear_addr, 32'hffff);
        $display("t_irq done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        step();
        t_reset();
        t_levels();
        t_flags();
        t_gates();
        t_lines();
        t_irq();
        wrap_up();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        $display("MISMATCH %0t watchdog", $time);
        wrap_up();
    end
endmodule // tb
